/* rtl/timer_pkg.sv */
/*
 Constants, register map and carrier types for the timer 0 / timer 1 pair.
 Assumes a single 25 MHz clock, synchronous active-high reset and an APB master with 32-bit data.
*/
package timer_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // Register indexes; the byte address is four times the index
   localparam logic [7:0] IDX_RUN_FLAG_CTRL       = 8'h88;
   localparam logic [7:0] IDX_MODE_SELECT         = 8'h89;
   localparam logic [7:0] IDX_T0_COUNT_LOW        = 8'h8a;
   localparam logic [7:0] IDX_T1_COUNT_LOW        = 8'h8b;
   localparam logic [7:0] IDX_T0_COUNT_HIGH       = 8'h8c;
   localparam logic [7:0] IDX_T1_COUNT_HIGH       = 8'h8d;
   localparam logic [7:0] IDX_PRESCALE_TOGGLE     = 8'hce;

   localparam logic [7:0] RESET_BYTE              = 8'h00;
   localparam logic [7:0] PRESCALE_TOGGLE_MASK    = 8'h0f;

   // Run/flag control fields
   localparam int T1_OVF_FLAG_POS = 7;
   localparam int T1_RUN_POS      = 6;
   localparam int T0_OVF_FLAG_POS = 5;
   localparam int T0_RUN_POS      = 4;
   // Mode select fields
   localparam int T1_GATE_POS     = 7;
   localparam int T1_CSEL_POS     = 6;
   localparam int T1_MODE_LSB     = 4;
   localparam int T0_GATE_POS     = 3;
   localparam int T0_CSEL_POS     = 2;
   localparam int T0_MODE_LSB     = 0;
   // Prescale / toggle fields
   localparam int T1_PRESCALE_POS = 3;
   localparam int T0_PRESCALE_POS = 2;
   localparam int T1_TOGGLE_POS   = 1;
   localparam int T0_TOGGLE_POS   = 0;

   localparam logic [1:0] MODE_13BIT   = 2'h0;
   localparam logic [1:0] MODE_16BIT   = 2'h1;
   localparam logic [1:0] MODE_RELOAD8 = 2'h2;
   localparam logic [1:0] MODE_SPLIT   = 2'h3;

   localparam int PRESCALE_DIV = 12;

   // Sampled pin indexes
   localparam int NUM_PINS = 4;
   localparam int PIN_T0   = 0;
   localparam int PIN_T1   = 1;
   localparam int PIN_INT0 = 2;
   localparam int PIN_INT1 = 3;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] prdata;
      logic              pready;
      logic              pslverr;
   } apb_rsp_t;

   typedef struct packed {
      logic       ovf;
      logic [7:0] low;
      logic [7:0] high;
   } count_step_t;
endpackage : timer_pkg

/* rtl/pin_sampler.sv */
/*
 Two-flop synchronisers with falling-edge detection for the count and gate pins.
 Assumes the pins are slow compared to the clock.
*/
`timescale 1ns/100ps
module pin_sampler #(
   parameter int WIDTH = 4
) (
   input  wire logic             ref_clk,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] pin_raw,
   output      logic [WIDTH-1:0] pin_level,
   output      logic [WIDTH-1:0] pin_fall
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] prev;

   if (WIDTH < 1) begin : g_bad_width
      $error("pin_sampler needs at least one pin");
   end

   for (genvar i = 0; i < WIDTH; i++) begin : g_pin
      always_ff @(posedge ref_clk) begin
         if (srst) begin
            meta[i]      <= 1'b1;
            pin_level[i] <= 1'b1;
            prev[i]      <= 1'b1;
         end else begin
            meta[i]      <= pin_raw[i];
            pin_level[i] <= meta[i];
            prev[i]      <= pin_level[i];
         end
      end
      // Edge found from second and third samples only
      assign pin_fall[i] = prev[i] & ~pin_level[i];
   end
endmodule : pin_sampler

/* rtl/prescale_tick.sv */
/*
 Free-running divider giving a one-cycle tick every DIV clocks.
 Assumes the single system clock.
*/
`timescale 1ns/100ps
module prescale_tick #(
   parameter int DIV = 12
) (
   input  wire logic ref_clk,
   input  wire logic srst,
   output      logic tick
);
   localparam int CW = $clog2(DIV);
   logic [CW-1:0] count;

   if (DIV < 2) begin : g_bad_div
      $error("prescale_tick needs DIV of at least 2");
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         count <= '0;
         tick  <= 1'b0;
      end else if (count == CW'(DIV - 1)) begin
         count <= '0;
         tick  <= 1'b1;
      end else begin
         count <= count + CW'(1);
         tick  <= 1'b0;
      end
   end
endmodule : prescale_tick

/* rtl/dual_timer_counter_pair.sv */
/*
 Timer 0 and timer 1 with all four modes, gate, counter and prescale options,
 pin toggle on overflow and an APB register slave.
 Assumes count and gate pins are asynchronous inputs sampled here, and that the
 interrupt controller outside watches the overflow flags and request pulses.
*/
// Design decision made here: register access over APB.
`timescale 1ns/100ps
module dual_timer_counter_pair #(
   parameter int PRESCALE_DIV = timer_pkg::PRESCALE_DIV
) (
   input  wire logic                ref_clk,
   input  wire logic                srst,
   input  wire timer_pkg::apb_req_t apb_req,
   output      timer_pkg::apb_rsp_t apb_rsp,
   input  wire logic                timer0_pin_in,
   input  wire logic                timer1_pin_in,
   input  wire logic [1:0]          external_interrupt_pin,
   output      logic                timer0_pin_out,
   output      logic                timer0_pin_oe,
   output      logic                timer1_pin_out,
   output      logic                timer1_pin_oe,
   output      logic                timer1_pin_pullup_en,
   output      logic                timer0_overflow_flag,
   output      logic                timer1_overflow_flag,
   output      logic                timer0_sw_irq_pulse,
   output      logic                timer1_sw_irq_pulse,
   output      logic                timer1_baud_tick,
   output      logic [3:0]          ext_irq_ctrl
);
   if (PRESCALE_DIV < 2) begin : g_bad_div
      $error("PRESCALE_DIV must be at least 2");
   end

   // Register state
   logic [7:0] run_ctrl;
   logic [7:0] timer_mode_select;
   logic [7:0] timer0_count_low;
   logic [7:0] timer0_count_high;
   logic [7:0] timer1_count_low;
   logic [7:0] timer1_count_high;
   logic [7:0] timer_prescale_toggle_ctrl;

   // Pin sampling and clock sources
   logic [timer_pkg::NUM_PINS-1:0] pin_level;
   logic [timer_pkg::NUM_PINS-1:0] pin_fall;
   logic                           tick12;

   pin_sampler #(
      .WIDTH (timer_pkg::NUM_PINS)
   ) u_pins (
      .ref_clk   (ref_clk),
      .srst      (srst),
      .pin_raw   ({external_interrupt_pin[1], external_interrupt_pin[0], timer1_pin_in, timer0_pin_in}),
      .pin_level (pin_level),
      .pin_fall  (pin_fall)
   );

   prescale_tick #(
      .DIV (PRESCALE_DIV)
   ) u_prescale (
      .ref_clk (ref_clk),
      .srst    (srst),
      .tick    (tick12)
   );

   // One counting step for a timer in modes 0, 1, 2; split low byte uses default
   function automatic timer_pkg::count_step_t count_step(input logic [1:0] mode,
                                                         input logic [7:0] low,
                                                         input logic [7:0] high);
      timer_pkg::count_step_t r;
      logic [12:0]            c13;
      logic [15:0]            c16;
      r   = '{ovf: 1'b0, low: low, high: high};
      c13 = '0;
      c16 = '0;
      case (mode)
         timer_pkg::MODE_13BIT: begin
            c13    = {high, low[4:0]} + 13'h0001;
            r.low  = {low[7:5], c13[4:0]};
            r.high = c13[12:5];
            r.ovf  = &{high, low[4:0]};
         end
         timer_pkg::MODE_16BIT: begin
            c16    = {high, low} + 16'h0001;
            r.low  = c16[7:0];
            r.high = c16[15:8];
            r.ovf  = &{high, low};
         end
         timer_pkg::MODE_RELOAD8: begin
            r.ovf = &low;
            r.low = (&low) ? high : low + 8'h01;
         end
         default: begin
            r.ovf = &low;
            r.low = low + 8'h01;
         end
      endcase
      return r;
   endfunction : count_step

   // Control fields
   logic [1:0] mode0;
   logic [1:0] mode1;
   logic       split;
   logic       run0;
   logic       run1;
   logic       gate0;
   logic       gate1;
   logic       csel0;
   logic       csel1;
   logic       pre0;
   logic       pre1;
   logic       tog0;
   logic       tog1;

   assign mode0 = timer_mode_select[timer_pkg::T0_MODE_LSB +: 2];
   assign mode1 = timer_mode_select[timer_pkg::T1_MODE_LSB +: 2];
   assign split = (mode0 == timer_pkg::MODE_SPLIT);
   assign run0  = run_ctrl[timer_pkg::T0_RUN_POS];
   assign run1  = run_ctrl[timer_pkg::T1_RUN_POS];
   assign gate0 = timer_mode_select[timer_pkg::T0_GATE_POS];
   assign gate1 = timer_mode_select[timer_pkg::T1_GATE_POS];
   assign csel0 = timer_mode_select[timer_pkg::T0_CSEL_POS];
   assign csel1 = timer_mode_select[timer_pkg::T1_CSEL_POS];
   assign pre0  = timer_prescale_toggle_ctrl[timer_pkg::T0_PRESCALE_POS];
   assign pre1  = timer_prescale_toggle_ctrl[timer_pkg::T1_PRESCALE_POS];
   assign tog0  = timer_prescale_toggle_ctrl[timer_pkg::T0_TOGGLE_POS];
   assign tog1  = timer_prescale_toggle_ctrl[timer_pkg::T1_TOGGLE_POS];

   // Count enables
   logic clk_tick0;
   logic clk_tick1;
   logic src_tick0;
   logic src_tick1;
   logic gate_ok0;
   logic gate_ok1;
   logic inc_t0;
   logic inc_th0;
   logic inc_t1;

   assign clk_tick0 = pre0 | tick12;
   assign clk_tick1 = pre1 | tick12;
   assign src_tick0 = csel0 ? pin_fall[timer_pkg::PIN_T0] : clk_tick0;
   assign src_tick1 = csel1 ? pin_fall[timer_pkg::PIN_T1] : clk_tick1;
   assign gate_ok0  = ~gate0 | pin_level[timer_pkg::PIN_INT0];
   assign gate_ok1  = ~gate1 | pin_level[timer_pkg::PIN_INT1];

   // Timer 0 (whole, or its low byte in split mode) uses timer 0 controls
   assign inc_t0  = run0 & gate_ok0 & src_tick0;
   // Split high byte: timer 1 run bit, clock source only
   assign inc_th0 = split & run1 & clk_tick0;

   always_comb begin
      if (split) begin
         inc_t1 = (mode1 != timer_pkg::MODE_SPLIT) & clk_tick1;
      end else begin
         inc_t1 = (mode1 != timer_pkg::MODE_SPLIT) & run1 & gate_ok1 & src_tick1;
      end
   end

   timer_pkg::count_step_t step0;
   timer_pkg::count_step_t step1;
   logic                   ovf0;
   logic                   ovf_th0;
   logic                   ovf1;

   assign step0   = count_step(mode0, timer0_count_low, timer0_count_high);
   assign step1   = count_step(mode1, timer1_count_low, timer1_count_high);
   assign ovf0    = inc_t0 & step0.ovf;
   assign ovf_th0 = inc_th0 & (&timer0_count_high);
   assign ovf1    = inc_t1 & step1.ovf;

   // APB decode
   logic [7:0] req_idx;
   logic       setup;
   logic       wr_en;

   function automatic logic is_mapped(input logic [timer_pkg::ADDR_W-1:0] a);
      logic [7:0] i;
      i = a[9:2];
      return (a[1:0] == 2'h0) && (a[timer_pkg::ADDR_W-1:10] == '0) &&
             (((i >= timer_pkg::IDX_RUN_FLAG_CTRL) && (i <= timer_pkg::IDX_T1_COUNT_HIGH)) ||
              (i == timer_pkg::IDX_PRESCALE_TOGGLE));
   endfunction : is_mapped

   function automatic logic wr_hit(input logic we, input logic [7:0] idx, input logic [7:0] target);
      return we && (idx == target);
   endfunction : wr_hit

   assign req_idx = apb_req.paddr[9:2];
   assign setup   = apb_req.psel & ~apb_req.penable;
   assign wr_en   = apb_req.psel & apb_req.penable & apb_rsp.pready & apb_req.pwrite & is_mapped(apb_req.paddr);

   logic [7:0] read_byte;
   always_comb begin
      case (req_idx)
         timer_pkg::IDX_RUN_FLAG_CTRL:
            read_byte = {timer1_overflow_flag, run_ctrl[6], timer0_overflow_flag, run_ctrl[4:0]};
         timer_pkg::IDX_MODE_SELECT:     read_byte = timer_mode_select;
         timer_pkg::IDX_T0_COUNT_LOW:    read_byte = timer0_count_low;
         timer_pkg::IDX_T1_COUNT_LOW:    read_byte = timer1_count_low;
         timer_pkg::IDX_T0_COUNT_HIGH:   read_byte = timer0_count_high;
         timer_pkg::IDX_T1_COUNT_HIGH:   read_byte = timer1_count_high;
         timer_pkg::IDX_PRESCALE_TOGGLE: read_byte = timer_prescale_toggle_ctrl;
         default:                        read_byte = 8'h00;
      endcase
   end

   // Answer in the first access cycle; read data captured in the setup cycle
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         apb_rsp <= '0;
      end else begin
         apb_rsp.pready  <= setup;
         apb_rsp.pslverr <= setup & ~is_mapped(apb_req.paddr);
         if (setup) begin
            apb_rsp.prdata <= is_mapped(apb_req.paddr) ? {24'h000000, read_byte} : '0;
         end
      end
   end

   // Control registers
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         run_ctrl                   <= timer_pkg::RESET_BYTE;
         timer_mode_select          <= timer_pkg::RESET_BYTE;
         timer_prescale_toggle_ctrl <= timer_pkg::RESET_BYTE;
      end else begin
         if (wr_hit(wr_en, req_idx, timer_pkg::IDX_RUN_FLAG_CTRL)) begin
            run_ctrl <= apb_req.pwdata[7:0];
         end
         if (wr_hit(wr_en, req_idx, timer_pkg::IDX_MODE_SELECT)) begin
            timer_mode_select <= apb_req.pwdata[7:0];
         end
         if (wr_hit(wr_en, req_idx, timer_pkg::IDX_PRESCALE_TOGGLE)) begin
            timer_prescale_toggle_ctrl <= apb_req.pwdata[7:0] & timer_pkg::PRESCALE_TOGGLE_MASK;
         end
      end
   end

   assign ext_irq_ctrl = run_ctrl[3:0];

   // Overflow flags: hardware set wins over a software clear in the same cycle
   logic wr_flags;
   assign wr_flags = wr_hit(wr_en, req_idx, timer_pkg::IDX_RUN_FLAG_CTRL);

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         timer0_overflow_flag <= 1'b0;
         timer1_overflow_flag <= 1'b0;
         timer0_sw_irq_pulse  <= 1'b0;
         timer1_sw_irq_pulse  <= 1'b0;
      end else begin
         if (ovf0) begin
            timer0_overflow_flag <= 1'b1;
         end else if (wr_flags) begin
            timer0_overflow_flag <= apb_req.pwdata[timer_pkg::T0_OVF_FLAG_POS];
         end
         if (ovf_th0 | (ovf1 & ~split)) begin
            timer1_overflow_flag <= 1'b1;
         end else if (wr_flags) begin
            timer1_overflow_flag <= apb_req.pwdata[timer_pkg::T1_OVF_FLAG_POS];
         end
         timer0_sw_irq_pulse <= wr_flags & apb_req.pwdata[timer_pkg::T0_OVF_FLAG_POS];
         timer1_sw_irq_pulse <= wr_flags & apb_req.pwdata[timer_pkg::T1_OVF_FLAG_POS];
      end
   end

   // Timer 0 count bytes; software write wins over counting
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         timer0_count_low  <= timer_pkg::RESET_BYTE;
         timer0_count_high <= timer_pkg::RESET_BYTE;
      end else begin
         if (inc_t0) begin
            timer0_count_low <= step0.low;
            if (!split) begin
               timer0_count_high <= step0.high;
            end
         end
         if (inc_th0) begin
            timer0_count_high <= timer0_count_high + 8'h01;
         end
         if (wr_hit(wr_en, req_idx, timer_pkg::IDX_T0_COUNT_LOW)) begin
            timer0_count_low <= apb_req.pwdata[7:0];
         end
         if (wr_hit(wr_en, req_idx, timer_pkg::IDX_T0_COUNT_HIGH)) begin
            timer0_count_high <= apb_req.pwdata[7:0];
         end
      end
   end

   // Timer 1 count bytes
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         timer1_count_low  <= timer_pkg::RESET_BYTE;
         timer1_count_high <= timer_pkg::RESET_BYTE;
      end else begin
         if (inc_t1) begin
            timer1_count_low  <= step1.low;
            timer1_count_high <= step1.high;
         end
         // Touching these while timer 1 is the baud clock disturbs the rate
         if (wr_hit(wr_en, req_idx, timer_pkg::IDX_T1_COUNT_LOW)) begin
            timer1_count_low <= apb_req.pwdata[7:0];
         end
         if (wr_hit(wr_en, req_idx, timer_pkg::IDX_T1_COUNT_HIGH)) begin
            timer1_count_high <= apb_req.pwdata[7:0];
         end
      end
   end

   // Pin toggle, output enables, pull-up and baud tick
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         timer0_pin_out       <= 1'b0;
         timer1_pin_out       <= 1'b0;
         timer0_pin_oe        <= 1'b0;
         timer1_pin_oe        <= 1'b0;
         timer1_pin_pullup_en <= 1'b1;
         timer1_baud_tick     <= 1'b0;
      end else begin
         if (ovf0 & tog0 & ~csel0) begin
            timer0_pin_out <= ~timer0_pin_out;
         end
         if (ovf1 & tog1 & (~csel1 | split)) begin
            timer1_pin_out <= ~timer1_pin_out;
         end
         timer0_pin_oe        <= tog0;
         timer1_pin_oe        <= tog1;
         timer1_pin_pullup_en <= ~split;
         timer1_baud_tick     <= ovf1;
      end
   end
endmodule : dual_timer_counter_pair

/* sim/far_pins.sv */
/*
 Far-side pin model: count pins idle high on their pull-ups, gate pins set by the bench.
 Assumes the timer pair's clock; pins change just after a rising edge.
*/
`timescale 1ns/100ps
module far_pins (
   input  wire logic       ref_clk,
   output      logic       t0_pin,
   output      logic       t1_pin,
   output      logic [1:0] gate
);
   initial begin
      t0_pin = 1'b1;
      t1_pin = 1'b1;
      gate = 2'b11;
   end

   // Edges spaced well beyond the synchroniser delay
   task automatic falls(input int n);
      repeat (n) begin
         repeat (4) @(posedge ref_clk);
         t0_pin <= 1'b0;
         repeat (4) @(posedge ref_clk);
         t0_pin <= 1'b1;
      end
   endtask : falls

   task automatic set_gate(input logic [1:0] g);
      gate <= g;
   endtask : set_gate
endmodule : far_pins

/* sim/timer_pair_properties.sv */
/*
 Port-level assertions for the timer pair.
 Assumes binding to the top module; shadows mode and toggle bytes from APB writes.
*/
`timescale 1ns/100ps
module timer_pair_properties (
   input wire logic                ref_clk,
   input wire logic                srst,
   input wire timer_pkg::apb_req_t apb_req,
   input wire timer_pkg::apb_rsp_t apb_rsp,
   input wire logic                timer0_pin_oe,
   input wire logic                timer1_pin_pullup_en,
   input wire logic                timer0_sw_irq_pulse,
   input wire logic [3:0]          ext_irq_ctrl
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   logic [7:0] mode_sh;
   logic [7:0] tog_sh;
   wire [9:0] ix = apb_req.paddr[11:2];
   wire setup = apb_req.psel && !apb_req.penable;
   wire wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
   wire mapped = apb_req.paddr[1:0] == 2'h0 &&
                 ix inside {10'h088, 10'h089, 10'h08a, 10'h08b, 10'h08c, 10'h08d, 10'h0ce};

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         mode_sh <= 8'h00;
         tog_sh <= 8'h00;
      end else if (wr && ix == 10'h089) begin
         mode_sh <= apb_req.pwdata[7:0];
      end else if (wr && ix == 10'h0ce) begin
         tog_sh <= apb_req.pwdata[7:0];
      end
   end

   sequence s_ctrl_wr;
      wr && ix == 10'h088;
   endsequence

   a_ready_after_setup: assert property (setup |=> apb_rsp.pready)
      else $error("pready missing after setup");
   a_ready_one_cycle: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready held too long");
   a_unmapped_error: assert property (setup && !mapped |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
      else $error("unmapped access not refused");
   a_pullup_split: assert property ($stable(mode_sh[1:0]) |->
      timer1_pin_pullup_en == (mode_sh[1:0] != 2'h3))
      else $error("pull-up enable wrong for mode");
   a_oe_tracks_toggle: assert property (timer0_pin_oe == $past(tog_sh[0]))
      else $error("pin output enable not following toggle bit");
   a_sw_flag_pulse: assert property (s_ctrl_wr ##0 apb_req.pwdata[5] |=> timer0_sw_irq_pulse)
      else $error("software flag set gave no request");
   a_pulse_single: assert property (timer0_sw_irq_pulse |=> !timer0_sw_irq_pulse)
      else $error("request pulse longer than a cycle");
   a_ext_ctrl_write: assert property (s_ctrl_wr |=> ext_irq_ctrl == $past(apb_req.pwdata[3:0]))
      else $error("ext irq bits not written");
endmodule : timer_pair_properties

bind dual_timer_counter_pair timer_pair_properties u_props (.ref_clk, .srst, .apb_req, .apb_rsp,
   .timer0_pin_oe, .timer1_pin_pullup_en, .timer0_sw_irq_pulse, .ext_irq_ctrl);

/* sim/testbench.sv */
/*
 Self-checking bench for the timer pair: registers, modes, split, gate, counter, toggle.
 Assumes the far-pin model and the bound checker.
*/
`timescale 1ns/100ps
module testbench;
   localparam logic [7:0] CT = timer_pkg::IDX_RUN_FLAG_CTRL;
   localparam logic [7:0] MD = timer_pkg::IDX_MODE_SELECT;
   localparam logic [7:0] L0 = timer_pkg::IDX_T0_COUNT_LOW;
   localparam logic [7:0] L1 = timer_pkg::IDX_T1_COUNT_LOW;
   localparam logic [7:0] H0 = timer_pkg::IDX_T0_COUNT_HIGH;
   localparam logic [7:0] H1 = timer_pkg::IDX_T1_COUNT_HIGH;
   localparam logic [7:0] PT = timer_pkg::IDX_PRESCALE_TOGGLE;
   logic                ref_clk = 1'b0;
   logic                srst = 1'b1;
   timer_pkg::apb_req_t apb_req = '0;
   timer_pkg::apb_rsp_t apb_rsp;
   logic                t0_in, t1_in, t0_out, t0_oe, t1_out, t1_oe, pu, f0, f1, p0, p1, baud, err;
   logic [1:0]          gate;
   logic [3:0]          eic;
   logic [7:0]          q;
   logic [2:0]          ev;
   assign ev = {baud, f1, f0};
   int                  n_errors = 0;
   int                  n_checks = 0;

   dual_timer_counter_pair u_dut (.ref_clk(ref_clk), .srst(srst), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .timer0_pin_in(t0_in), .timer1_pin_in(t1_in), .external_interrupt_pin(gate),
      .timer0_pin_out(t0_out), .timer0_pin_oe(t0_oe), .timer1_pin_out(t1_out), .timer1_pin_oe(t1_oe),
      .timer1_pin_pullup_en(pu), .timer0_overflow_flag(f0), .timer1_overflow_flag(f1),
      .timer0_sw_irq_pulse(p0), .timer1_sw_irq_pulse(p1), .timer1_baud_tick(baud), .ext_irq_ctrl(eic));
   far_pins u_far (.ref_clk(ref_clk), .t0_pin(t0_in), .t1_pin(t1_in), .gate(gate));

   initial forever #20 ref_clk = ~ref_clk;

   task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
      apb_req <= '{1'b1, 1'b0, w, {2'h0, i, 2'h0}, {24'h0, d}};
      @(posedge ref_clk);
      apb_req.penable <= 1'b1;
      // Only the watchdog ends a wait for the slave
      do begin
         @(posedge ref_clk);
      end while (apb_rsp.pready !== 1'b1);
      q = apb_rsp.prdata[7:0];
      err = apb_rsp.pslverr;
      apb_req <= '0;
      @(posedge ref_clk);
   endtask : apb

   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      apb(1'b1, i, d);
   endtask : wr

   task automatic rd(input logic [7:0] i, input logic [7:0] exp);
      apb(1'b0, i, 8'h00);
      check($sformatf("reg %h", i), q, exp);
   endtask : rd

   // Polls t0 flag, t1 flag or baud tick under a cycle limit
   task automatic wait_hi(input int sel, input int lim);
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (ev[sel] !== 1'b1 && n < lim);
      check($sformatf("event %0d", sel), {7'h0, ev[sel]}, 8'h01);
   endtask : wait_hi

   task automatic t_regs;
      logic [7:0] idx [7] = '{CT, MD, L0, L1, H0, H1, PT};
      foreach (idx[k]) rd(idx[k], 8'h00);
      foreach (idx[k]) wr(idx[k], k == 0 ? 8'h0f : 8'ha5);
      foreach (idx[k]) rd(idx[k], k == 0 ? 8'h0f : (k == 6 ? 8'h05 : 8'ha5));
      check("ext_irq_ctrl", {4'h0, eic}, 8'h0f);
      check("t0_oe", {7'h0, t0_oe}, 8'h01);
      wr(PT, 8'h02);
      // Output enable follows the register one cycle later
      @(posedge ref_clk);
      check("t1_oe", {7'h0, t1_oe}, 8'h01);
      apb(1'b0, 8'h90, 8'h00);
      check("slverr", {7'h0, err}, 8'h01);
      foreach (idx[k]) wr(idx[k], 8'h00);
   endtask : t_regs

   task automatic t_mode1;
      logic [7:0] q1;
      wr(PT, 8'h05);
      wr(MD, 8'h01);
      wr(H0, 8'hff);
      wr(L0, 8'hf0);
      wr(CT, 8'h10);
      wait_hi(0, 40);
      wr(CT, 8'h00);
      check("t0_out", {7'h0, t0_out}, 8'h01);
      check("t0_flag_clr", {7'h0, f0}, 8'h00);
      rd(H0, 8'h00);
      apb(1'b0, L0, 8'h00);
      q1 = q;
      repeat (20) @(posedge ref_clk);
      rd(L0, q1);
      wr(CT, 8'hb0);
      check("t0_flag_sw", {7'h0, f0}, 8'h01);
      check("sw_flags", {5'h0, p0, p1, f1}, 8'h07);
      wr(CT, 8'h00);
      apb(1'b0, L0, 8'h00);
      check("resume", {7'h0, q > q1 && q < q1 + 8'd10}, 8'h01);
   endtask : t_mode1

   task automatic t_reload;
      wr(MD, 8'h02);
      wr(H0, 8'hf0);
      wr(L0, 8'hfe);
      wr(CT, 8'h10);
      wait_hi(0, 40);
      repeat (20) @(posedge ref_clk);
      wr(CT, 8'h00);
      rd(H0, 8'hf0);
      apb(1'b0, L0, 8'h00);
      check("reload", {4'h0, q[7:4]}, 8'h0f);
      // 13-bit: one step from all ones in the low five bits
      wr(MD, 8'h00);
      wr(CT, 8'h00);
      wr(H0, 8'hff);
      wr(L0, 8'h1f);
      wr(CT, 8'h10);
      wait_hi(0, 6);
      wr(CT, 8'h00);
   endtask : t_reload

   task automatic t_pace;
      u_far.set_gate(2'b10);
      wr(PT, 8'h00);
      wr(MD, 8'h01);
      wr(L0, 8'h00);
      wr(CT, 8'h10);
      repeat (120) @(posedge ref_clk);
      wr(CT, 8'h00);
      apb(1'b0, L0, 8'h00);
      check("div12", {7'h0, q inside {8'd10, 8'd11}}, 8'h01);
      wr(PT, 8'h04);
      wr(MD, 8'h09);
      wr(L0, 8'h00);
      wr(CT, 8'h10);
      repeat (20) @(posedge ref_clk);
      rd(L0, 8'h00);
      u_far.set_gate(2'b11);
      repeat (20) @(posedge ref_clk);
      wr(CT, 8'h00);
      apb(1'b0, L0, 8'h00);
      check("gated", {7'h0, q > 8'd15}, 8'h01);
      wr(MD, 8'h05);
      wr(L0, 8'h00);
      wr(CT, 8'h10);
      u_far.falls(3);
      repeat (8) @(posedge ref_clk);
      wr(CT, 8'h00);
      rd(L0, 8'h03);
   endtask : t_pace

   task automatic t_split;
      logic [7:0] q1;
      u_far.set_gate(2'b01);
      wr(PT, 8'h0e);
      wr(MD, 8'h93);
      wr(H0, 8'h00);
      // Timer 1 bytes loaded after split mode has already started it counting for the serial port
      wr(H1, 8'hff);
      wr(L1, 8'hf0);
      wait_hi(2, 40);
      check("t1_flag", {7'h0, f1}, 8'h00);
      check("t1_out", {7'h0, t1_out}, 8'h01);
      check("pullup", {7'h0, pu}, 8'h00);
      rd(H0, 8'h00);
      wr(H0, 8'hf0);
      wr(CT, 8'h40);
      wait_hi(1, 40);
      wr(CT, 8'h00);
      wr(MD, 8'h33);
      apb(1'b0, L1, 8'h00);
      q1 = q;
      repeat (10) @(posedge ref_clk);
      rd(L1, q1);
   endtask : t_split

   task automatic complete_run;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run

   initial begin
      #800000;
      n_errors++;
      complete_run();
   end

   initial begin
      repeat (5) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      t_regs();
      t_mode1();
      t_reload();
      t_pace();
      t_split();
      complete_run();
   end
endmodule : testbench
